// ### design/interrupt_priority_register_bank.v
// Interrupt priority register bank: five 16-bit level registers over AXI4-Lite
// Assumes one clock, synchronous active-low reset, arbitration logic downstream
//
// Notes on behaviour
// - The first register holds levels of external lines 0,1,2,3 from top nibble to lowest.
// - The second register holds levels of external lines 4,5,6,7 from top nibble to lowest.
// - The top nibble of the third register is one level shared by DMA channels 0 and 1.
// - The second nibble of the third register is one level shared by DMA channels 2 and 3.
// - The third register keeps timer channel 0 in bits 7-4 and timer channel 1 in bits 3-0.
// - The fourth register holds timer channels 2,3,4 in its top nibbles, serial channel 0 lowest.
// - The top nibble of the fifth register is the level of all serial channel 1 requests.
// - The second nibble of the fifth register is shared by the parity checker and the converter.
// - Bits 7-4 of the fifth register are shared by the watchdog unit and memory refresh.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "priority_bank_defs.vh"
module interrupt_priority_register_bank #(
  parameter AW = 32,
  parameter DW = 32,
  parameter LW = `LEVEL_W
) (
  input  wire            aclk,
  input  wire            aresetn,
  input  wire            s_axi_awvalid,
  output wire            s_axi_awready,
  input  wire [AW-1:0]   s_axi_awaddr,
  input  wire [2:0]      s_axi_awprot,
  input  wire            s_axi_wvalid,
  output wire            s_axi_wready,
  input  wire [DW-1:0]   s_axi_wdata,
  input  wire [DW/8-1:0] s_axi_wstrb,
  output wire            s_axi_bvalid,
  input  wire            s_axi_bready,
  output wire [1:0]      s_axi_bresp,
  input  wire            s_axi_arvalid,
  output wire            s_axi_arready,
  input  wire [AW-1:0]   s_axi_araddr,
  input  wire [2:0]      s_axi_arprot,
  output wire            s_axi_rvalid,
  input  wire            s_axi_rready,
  output wire [DW-1:0]   s_axi_rdata,
  output wire [1:0]      s_axi_rresp,
  output wire [LW-1:0]   ext_line_0_level,
  output wire [LW-1:0]   ext_line_1_level,
  output wire [LW-1:0]   ext_line_2_level,
  output wire [LW-1:0]   ext_line_3_level,
  output wire [LW-1:0]   ext_line_4_level,
  output wire [LW-1:0]   ext_line_5_level,
  output wire [LW-1:0]   ext_line_6_level,
  output wire [LW-1:0]   ext_line_7_level,
  output wire [LW-1:0]   dma_channel_0_level,
  output wire [LW-1:0]   dma_channel_1_level,
  output wire [LW-1:0]   dma_channel_2_level,
  output wire [LW-1:0]   dma_channel_3_level,
  output wire [LW-1:0]   timer_channel_0_level,
  output wire [LW-1:0]   timer_channel_1_level,
  output wire [LW-1:0]   timer_channel_2_level,
  output wire [LW-1:0]   timer_channel_3_level,
  output wire [LW-1:0]   timer_channel_4_level,
  output wire [LW-1:0]   serial_channel_0_level,
  output wire [LW-1:0]   serial_channel_1_level,
  output wire [LW-1:0]   parity_checker_level,
  output wire [LW-1:0]   adc_level,
  output wire [LW-1:0]   watchdog_unit_level,
  output wire [LW-1:0]   refresh_level
);

  localparam NREG   = `NUM_REGS;
  localparam NFIELD = `NUM_REGS * `FIELDS_PER_REG;
  localparam RW     = `REG_W;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte addresses

  localparam [AW-1:0] ADDR_EXT_LINES_LOW      = `IDX_EXT_LINES_LOW * `ADDR_SCALE;
  localparam [AW-1:0] ADDR_EXT_LINES_HIGH     = `IDX_EXT_LINES_HIGH * `ADDR_SCALE;
  localparam [AW-1:0] ADDR_DMA_TIMER_LOW      = `IDX_DMA_TIMER_LOW * `ADDR_SCALE;
  localparam [AW-1:0] ADDR_TIMER_HIGH_SERIAL0 = `IDX_TIMER_HIGH_SERIAL0 * `ADDR_SCALE;
  localparam [AW-1:0] ADDR_SERIAL1_MISC       = `IDX_SERIAL1_MISC * `ADDR_SCALE;

  ////////////////////////////////////////////////////////////////////////////////
  // Write side

  wire [AW-1:0]     wr_addr;
  wire [DW-1:0]     wr_data;
  wire [DW/8-1:0]   wr_strb;
  wire              wr_pulse;
  reg  [NREG-1:0]   wr_sel;
  wire              wr_hit;
  wire [NFIELD*LW-1:0] levels;

  axil_write_capture #(
    .AW (AW),
    .DW (DW)
  ) write_port (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .awvalid  (s_axi_awvalid),
    .awaddr   (s_axi_awaddr),
    .awready  (s_axi_awready),
    .wvalid   (s_axi_wvalid),
    .wdata    (s_axi_wdata),
    .wstrb    (s_axi_wstrb),
    .wready   (s_axi_wready),
    .bvalid   (s_axi_bvalid),
    .bready   (s_axi_bready),
    .bresp    (s_axi_bresp),
    .addr_hit (wr_hit),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data),
    .wr_strb  (wr_strb),
    .wr_pulse (wr_pulse)
  );

  // Write address decode, one select per register
  always @* begin
    wr_sel = {NREG{1'b0}};
    case (wr_addr)
      ADDR_EXT_LINES_LOW:      wr_sel[`SLOT_EXT_LINES_LOW]      = 1'b1;
      ADDR_EXT_LINES_HIGH:     wr_sel[`SLOT_EXT_LINES_HIGH]     = 1'b1;
      ADDR_DMA_TIMER_LOW:      wr_sel[`SLOT_DMA_TIMER_LOW]      = 1'b1;
      ADDR_TIMER_HIGH_SERIAL0: wr_sel[`SLOT_TIMER_HIGH_SERIAL0] = 1'b1;
      ADDR_SERIAL1_MISC:       wr_sel[`SLOT_SERIAL1_MISC]       = 1'b1;
      default:                 wr_sel = {NREG{1'b0}};
    endcase
  end

  assign wr_hit = |wr_sel;

  ////////////////////////////////////////////////////////////////////////////////
  // Level fields; field i sits in register i/4 at nibble i%4

  genvar i;
  generate
    for (i = 0; i < NFIELD; i = i + 1) begin : field
      if (i == `RESERVED_FIELD) begin : reserved
        assign levels[i*LW +: LW] = `LEVEL_RESET;
      end else begin : stored
        wire lane_we;
        assign lane_we = wr_pulse && wr_sel[i / `FIELDS_PER_REG] &&
                         wr_strb[(i % `FIELDS_PER_REG) / `NIBBLES_PER_LANE];
        level_field #(
          .W (LW)
        ) level (
          .aclk    (aclk),
          .aresetn (aresetn),
          .we      (lane_we),
          .d       (wr_data[(i % `FIELDS_PER_REG)*LW +: LW]),
          .q       (levels[i*LW +: LW])
        );
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Register words as seen by software

  wire [RW-1:0] word_ext_lines_low;
  wire [RW-1:0] word_ext_lines_high;
  wire [RW-1:0] word_dma_timer_low;
  wire [RW-1:0] word_timer_high_serial0;
  wire [RW-1:0] word_serial1_misc;

  assign word_ext_lines_low      = levels[`SLOT_EXT_LINES_LOW*RW +: RW];
  assign word_ext_lines_high     = levels[`SLOT_EXT_LINES_HIGH*RW +: RW];
  assign word_dma_timer_low      = levels[`SLOT_DMA_TIMER_LOW*RW +: RW];
  assign word_timer_high_serial0 = levels[`SLOT_TIMER_HIGH_SERIAL0*RW +: RW];
  assign word_serial1_misc       = levels[`SLOT_SERIAL1_MISC*RW +: RW];

  ////////////////////////////////////////////////////////////////////////////////
  // Read side

  reg            arready_reg;
  reg            rvalid_reg;
  reg [DW-1:0]   rdata_reg;
  reg [1:0]      rresp_reg;
  reg [RW-1:0]   rd_word;
  reg            rd_hit;

  // Read address decode
  always @* begin
    rd_word = `REG_PAD;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      ADDR_EXT_LINES_LOW:      rd_word = word_ext_lines_low;
      ADDR_EXT_LINES_HIGH:     rd_word = word_ext_lines_high;
      ADDR_DMA_TIMER_LOW:      rd_word = word_dma_timer_low;
      ADDR_TIMER_HIGH_SERIAL0: rd_word = word_timer_high_serial0;
      ADDR_SERIAL1_MISC:       rd_word = word_serial1_misc;
      default: begin
        rd_word = `REG_PAD;
        rd_hit  = 1'b0;
      end
    endcase
  end

  // One read under way; answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= {DW{1'b0}};
      rresp_reg   <= `RESP_OKAY;
    end else begin
      if (arready_reg && s_axi_arvalid) begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rdata_reg   <= {{(DW-RW){1'b0}}, rd_word};
        rresp_reg   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid_reg && s_axi_rready) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Per-source levels to the arbitration logic

  // External lines, first register
  assign ext_line_0_level =
    levels[(`SLOT_EXT_LINES_LOW*`FIELDS_PER_REG + `NIB_TOP)*LW +: LW];
  assign ext_line_1_level =
    levels[(`SLOT_EXT_LINES_LOW*`FIELDS_PER_REG + `NIB_SECOND)*LW +: LW];
  assign ext_line_2_level =
    levels[(`SLOT_EXT_LINES_LOW*`FIELDS_PER_REG + `NIB_THIRD)*LW +: LW];
  assign ext_line_3_level =
    levels[(`SLOT_EXT_LINES_LOW*`FIELDS_PER_REG + `NIB_LOW)*LW +: LW];

  // External lines, second register
  assign ext_line_4_level =
    levels[(`SLOT_EXT_LINES_HIGH*`FIELDS_PER_REG + `NIB_TOP)*LW +: LW];
  assign ext_line_5_level =
    levels[(`SLOT_EXT_LINES_HIGH*`FIELDS_PER_REG + `NIB_SECOND)*LW +: LW];
  assign ext_line_6_level =
    levels[(`SLOT_EXT_LINES_HIGH*`FIELDS_PER_REG + `NIB_THIRD)*LW +: LW];
  assign ext_line_7_level =
    levels[(`SLOT_EXT_LINES_HIGH*`FIELDS_PER_REG + `NIB_LOW)*LW +: LW];

  // DMA channel pairs share one field each
  assign dma_channel_0_level =
    levels[(`SLOT_DMA_TIMER_LOW*`FIELDS_PER_REG + `NIB_TOP)*LW +: LW];
  assign dma_channel_1_level =
    levels[(`SLOT_DMA_TIMER_LOW*`FIELDS_PER_REG + `NIB_TOP)*LW +: LW];
  assign dma_channel_2_level =
    levels[(`SLOT_DMA_TIMER_LOW*`FIELDS_PER_REG + `NIB_SECOND)*LW +: LW];
  assign dma_channel_3_level =
    levels[(`SLOT_DMA_TIMER_LOW*`FIELDS_PER_REG + `NIB_SECOND)*LW +: LW];

  // Timer channels
  assign timer_channel_0_level =
    levels[(`SLOT_DMA_TIMER_LOW*`FIELDS_PER_REG + `NIB_THIRD)*LW +: LW];
  assign timer_channel_1_level =
    levels[(`SLOT_DMA_TIMER_LOW*`FIELDS_PER_REG + `NIB_LOW)*LW +: LW];
  assign timer_channel_2_level =
    levels[(`SLOT_TIMER_HIGH_SERIAL0*`FIELDS_PER_REG + `NIB_TOP)*LW +: LW];
  assign timer_channel_3_level =
    levels[(`SLOT_TIMER_HIGH_SERIAL0*`FIELDS_PER_REG + `NIB_SECOND)*LW +: LW];
  assign timer_channel_4_level =
    levels[(`SLOT_TIMER_HIGH_SERIAL0*`FIELDS_PER_REG + `NIB_THIRD)*LW +: LW];

  // Serial channels
  assign serial_channel_0_level =
    levels[(`SLOT_TIMER_HIGH_SERIAL0*`FIELDS_PER_REG + `NIB_LOW)*LW +: LW];
  assign serial_channel_1_level =
    levels[(`SLOT_SERIAL1_MISC*`FIELDS_PER_REG + `NIB_TOP)*LW +: LW];

  // Shared miscellaneous sources
  assign parity_checker_level =
    levels[(`SLOT_SERIAL1_MISC*`FIELDS_PER_REG + `NIB_SECOND)*LW +: LW];
  assign adc_level =
    levels[(`SLOT_SERIAL1_MISC*`FIELDS_PER_REG + `NIB_SECOND)*LW +: LW];
  assign watchdog_unit_level =
    levels[(`SLOT_SERIAL1_MISC*`FIELDS_PER_REG + `NIB_THIRD)*LW +: LW];
  assign refresh_level =
    levels[(`SLOT_SERIAL1_MISC*`FIELDS_PER_REG + `NIB_THIRD)*LW +: LW];

endmodule // interrupt_priority_register_bank

// ### pkg/priority_bank_defs.vh
// Constants for the interrupt priority register bank
// Assumes inclusion by bare name from every design file that needs them
`ifndef PRIORITY_BANK_DEFS_VH
`define PRIORITY_BANK_DEFS_VH

// Register indices as printed; byte address is four times the index
`define IDX_EXT_LINES_LOW       32'h05ffff84
`define IDX_EXT_LINES_HIGH      32'h05ffff86
`define IDX_DMA_TIMER_LOW       32'h05ffff88
`define IDX_TIMER_HIGH_SERIAL0  32'h05ffff8a
`define IDX_SERIAL1_MISC        32'h05ffff8c
`define ADDR_SCALE              32'h00000004

// Register slot numbers within the bank
`define SLOT_EXT_LINES_LOW      3'h0
`define SLOT_EXT_LINES_HIGH     3'h1
`define SLOT_DMA_TIMER_LOW      3'h2
`define SLOT_TIMER_HIGH_SERIAL0 3'h3
`define SLOT_SERIAL1_MISC       3'h4

// Field layout
`define LEVEL_W                 4
`define REG_W                   16
`define FIELDS_PER_REG          4
`define NUM_REGS                5
`define LEVEL_RESET             4'h0
`define REG_PAD                 16'h0000
`define RESERVED_FIELD          16
`define NIBBLES_PER_LANE        2

// Nibble positions (field number inside a register)
`define NIB_TOP                 3
`define NIB_SECOND              2
`define NIB_THIRD               1
`define NIB_LOW                 0

// AXI4-Lite responses
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2

`endif

// ### design/level_field.v
// One 4-bit priority level field with byte-lane write enable
// Assumes write enable is a one-cycle pulse from the bus side
`timescale 1ns/10ps
module level_field #(
  parameter W = 4
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire         we,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] level_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      level_reg <= {W{1'b0}};
    end else if (we) begin
      level_reg <= d;
    end
  end

  assign q = level_reg;

endmodule // level_field

// ### design/axil_write_capture.v
// AXI4-Lite write channels: address, data, response
// Assumes the parent decodes wr_addr combinationally into addr_hit
`timescale 1ns/10ps
`include "priority_bank_defs.vh"
module axil_write_capture #(
  parameter AW = 32,
  parameter DW = 32
) (
  input  wire            aclk,
  input  wire            aresetn,
  input  wire            awvalid,
  input  wire [AW-1:0]   awaddr,
  output wire            awready,
  input  wire            wvalid,
  input  wire [DW-1:0]   wdata,
  input  wire [DW/8-1:0] wstrb,
  output wire            wready,
  output wire            bvalid,
  input  wire            bready,
  output wire [1:0]      bresp,
  input  wire            addr_hit,
  output wire [AW-1:0]   wr_addr,
  output wire [DW-1:0]   wr_data,
  output wire [DW/8-1:0] wr_strb,
  output wire            wr_pulse
);

  reg            awready_reg;
  reg            wready_reg;
  reg            bvalid_reg;
  reg [1:0]      bresp_reg;
  reg [AW-1:0]   addr_reg;
  reg [DW-1:0]   data_reg;
  reg [DW/8-1:0] strb_reg;
  wire           both_held;

  // Both halves captured, response not yet raised
  assign both_held = !awready_reg && !wready_reg && !bvalid_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RESP_OKAY;
      addr_reg    <= {AW{1'b0}};
      data_reg    <= {DW{1'b0}};
      strb_reg    <= {(DW/8){1'b0}};
    end else begin
      if (awready_reg && awvalid) begin
        awready_reg <= 1'b0;
        addr_reg    <= awaddr;
      end
      if (wready_reg && wvalid) begin
        wready_reg <= 1'b0;
        data_reg   <= wdata;
        strb_reg   <= wstrb;
      end
      if (both_held) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= addr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_reg && bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  assign awready  = awready_reg;
  assign wready   = wready_reg;
  assign bvalid   = bvalid_reg;
  assign bresp    = bresp_reg;
  assign wr_addr  = addr_reg;
  assign wr_data  = data_reg;
  assign wr_strb  = strb_reg;
  assign wr_pulse = both_held;

endmodule // axil_write_capture

// ### tb/priority_bank_checker.sv
// Concurrent checks on the priority register bank ports
// Assumes one clock aclk and the synchronous active-low reset aresetn
`timescale 1ns/10ps
`include "priority_bank_defs.vh"
module priority_bank_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_araddr,
  input wire        s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire [3:0]  dma_channel_0_level,
  input wire [3:0]  dma_channel_1_level,
  input wire [3:0]  dma_channel_2_level,
  input wire [3:0]  dma_channel_3_level,
  input wire [3:0]  timer_channel_0_level,
  input wire [3:0]  timer_channel_1_level,
  input wire [3:0]  serial_channel_1_level,
  input wire [3:0]  parity_checker_level,
  input wire [3:0]  adc_level,
  input wire [3:0]  watchdog_unit_level,
  input wire [3:0]  refresh_level
);
  localparam logic [31:0] ADDR_DT = `IDX_DMA_TIMER_LOW * `ADDR_SCALE;
  localparam logic [31:0] ADDR_SM = `IDX_SERIAL1_MISC * `ADDR_SCALE;
  logic [31:0] rd_addr_q;
  ////////////////////////////////////////////////////////////////
  // Address of the read in flight
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr_q <= 32'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_q <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  a_dma_low_shared: assert property (
    dma_channel_0_level == dma_channel_1_level) else $error("dma 0/1 levels differ");
  a_dma_high_shared: assert property (
    dma_channel_2_level == dma_channel_3_level) else $error("dma 2/3 levels differ");
  a_parity_adc_shared: assert property (
    parity_checker_level == adc_level) else $error("parity/converter levels differ");
  a_watchdog_refresh_shared: assert property (
    watchdog_unit_level == refresh_level) else $error("watchdog/refresh levels differ");
  a_levels_kept: assert property (
    $past(aresetn) && !$rose(s_axi_bvalid) |-> $stable({dma_channel_0_level,
    timer_channel_1_level, serial_channel_1_level, watchdog_unit_level}))
    else $error("level changed without a write");
  a_read_dma_timer: assert property (
    s_axi_rvalid && s_axi_rresp == `RESP_OKAY && rd_addr_q == ADDR_DT |->
    s_axi_rdata == {16'h0000, dma_channel_0_level, dma_channel_2_level,
    timer_channel_0_level, timer_channel_1_level}) else $error("third register read wrong");
  a_read_serial1: assert property (
    s_axi_rvalid && s_axi_rresp == `RESP_OKAY && rd_addr_q == ADDR_SM |->
    s_axi_rdata == {16'h0000, serial_channel_1_level, parity_checker_level,
    watchdog_unit_level, 4'h0}) else $error("fifth register read wrong");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
endmodule // priority_bank_checker

bind interrupt_priority_register_bank priority_bank_checker chk_u (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp,
  .dma_channel_0_level, .dma_channel_1_level, .dma_channel_2_level, .dma_channel_3_level,
  .timer_channel_0_level, .timer_channel_1_level, .serial_channel_1_level,
  .parity_checker_level, .adc_level, .watchdog_unit_level, .refresh_level);

// ### tb/arbitration_model.sv
// Model of the arbitration logic that consumes the priority levels
// Assumes 24 level nibbles, unused entries held at zero
`timescale 1ns/10ps
module arbitration_model (
  input  wire  [3:0] levels [24],
  output logic [3:0] top_level
);
  // Highest level among all sources
  always_comb begin
    top_level = 4'h0;
    for (int i = 0; i < 24; i++) begin
      if (levels[i] > top_level) begin
        top_level = levels[i];
      end
    end
  end
endmodule // arbitration_model

// ### tb/interrupt_priority_register_bank_tb.sv
// Testbench for the interrupt priority register bank
// Assumes a 10 MHz clock and an AXI4-Lite master made of the tasks below
`timescale 1ns/10ps
`include "priority_bank_defs.vh"
module interrupt_priority_register_bank_tb;
  typedef struct {logic [2:0] slot; logic [31:0] d; logic [3:0] s; logic [15:0] e;} row_t;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, data;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  resp;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [3:0]  lv [24];
  wire  [3:0]  top_level;
  int          error_cnt = 0;
  int          checked = 0;
  logic [31:0] addr_of [5] = '{`IDX_EXT_LINES_LOW * `ADDR_SCALE,
    `IDX_EXT_LINES_HIGH * `ADDR_SCALE, `IDX_DMA_TIMER_LOW * `ADDR_SCALE,
    `IDX_TIMER_HIGH_SERIAL0 * `ADDR_SCALE, `IDX_SERIAL1_MISC * `ADDR_SCALE};
  row_t        rows [7] = '{'{3'h0, 32'hffff1234, 4'h3, 16'h1234},
    '{3'h1, 32'h00005678, 4'h3, 16'h5678}, '{3'h2, 32'h00009abc, 4'h3, 16'h9abc},
    '{3'h3, 32'h0000def1, 4'h3, 16'hdef1}, '{3'h4, 32'h00002345, 4'h3, 16'h2340},
    '{3'h4, 32'h0000ffff, 4'h1, 16'h23f0}, '{3'h0, 32'h0000abcd, 4'h2, 16'hab34}};

  assign lv[19] = 4'h0;
  always #50 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////
  interrupt_priority_register_bank dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .ext_line_0_level(lv[0]), .ext_line_1_level(lv[1]),
    .ext_line_2_level(lv[2]), .ext_line_3_level(lv[3]), .ext_line_4_level(lv[4]),
    .ext_line_5_level(lv[5]), .ext_line_6_level(lv[6]), .ext_line_7_level(lv[7]),
    .dma_channel_0_level(lv[8]), .dma_channel_1_level(lv[20]), .dma_channel_2_level(lv[9]),
    .dma_channel_3_level(lv[21]), .timer_channel_0_level(lv[10]),
    .timer_channel_1_level(lv[11]), .timer_channel_2_level(lv[12]),
    .timer_channel_3_level(lv[13]), .timer_channel_4_level(lv[14]),
    .serial_channel_0_level(lv[15]), .serial_channel_1_level(lv[16]),
    .parity_checker_level(lv[17]), .adc_level(lv[22]), .watchdog_unit_level(lv[18]),
    .refresh_level(lv[23]));
  arbitration_model partner_u (.levels(lv), .top_level(top_level));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] view(input int s);
    return {16'h0000, lv[4*s], lv[4*s+1], lv[4*s+2], lv[4*s+3]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        done = 1'b1;
        resp = bresp;
      end
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_read(input logic [31:0] a);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        done = 1'b1;
        data = rdata;
        resp = rresp;
      end
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic end_of_test;
    $display("Checks made: %0d, mismatches: %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    foreach (rows[i]) begin
      axi_write(addr_of[rows[i].slot], rows[i].d, rows[i].s);
      check({30'h0, resp}, {30'h0, `RESP_OKAY});
      check(view(rows[i].slot), {16'h0000, rows[i].e});
      axi_read(addr_of[rows[i].slot]);
      check({30'h0, resp}, {30'h0, `RESP_OKAY});
      check(data, {16'h0000, rows[i].e});
    end
    check({16'h0000, lv[20], lv[21], lv[22], lv[23]}, 32'h00009a3f);
    check({28'h0, top_level}, 32'h0000000f);
    // Unmapped address leaves the first register alone
    axi_write(32'h17fffe14, 32'h0000ffff, 4'h3);
    check({30'h0, resp}, {30'h0, `RESP_SLVERR});
    axi_read(32'h17fffe14);
    check({30'h0, resp}, {30'h0, `RESP_SLVERR});
    check(data, 32'h0);
    check(view(0), 32'h0000ab34);
    // Reset in mid-run
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int k = 0; k < 5; k++) begin
      axi_read(addr_of[k]);
      check(data, 32'h0);
      check(view(k), 32'h0);
    end
    check({28'h0, top_level}, 32'h0);
    end_of_test;
  end
  initial begin
    repeat (3000) @(posedge aclk);
    error_cnt++;
    end_of_test;
  end
endmodule // interrupt_priority_register_bank_tb
